// >>> hw/vrad_decoder.sv
// Vector remap and abort decoder: registered address translation and abort flags
`timescale 1ns/1ps
`default_nettype none
module vrad_decoder #(
	parameter int FLASH_KB = 512, // On-chip flash size
	parameter int SRAM_KB = 32 // On-chip SRAM size
) (
	input wire logic sys_clk, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire logic reqValid, // Core access request
	input wire logic [31:0] reqAddr, // Core address
	input wire logic reqFetch, // 1 = instruction fetch
	input wire logic reqWrite, // 1 = data write
	input wire logic modeWrite, // Strobe to load mapping mode
	input wire logic [1:0] modeData, // New mapping mode
	output logic rspValid, // Translated access valid
	output logic [31:0] rspAddr, // Physical address to memories
	output logic rspWrite, // Write enable to memories
	output logic rspDataAbort, // Data abort to core
	output logic rspPrefetchAbort, // Abort tag carried with fetch
	output logic [1:0] mapMode // Current mapping mode
);
	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (!(FLASH_KB == 32 || FLASH_KB == 64 || FLASH_KB == 128 || FLASH_KB == 256 || FLASH_KB == 512))
		$error("vrad_decoder: unsupported flash size");
	if (!(SRAM_KB == 8 || SRAM_KB == 16 || SRAM_KB == 32))
		$error("vrad_decoder: unsupported SRAM size");

	localparam logic [31:0] FLASH_END = 32'(FLASH_KB * 1024);
	localparam logic [31:0] SRAM_END = vrad_pkg::SRAM_BASE + 32'(SRAM_KB * 1024);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		vrad_pkg::vrad_mode_e mode;
		logic valid;
		logic [31:0] addr;
		logic write;
		logic dAbort;
		logic pAbort;
	} vrad_state_s;

	vrad_state_s st_r;
	vrad_state_s st_nxt;
	logic pbusPresent;
	logic ahbPresent;

	// Slot lookups; only the slot index is decoded, offsets alias inside a slot
	vrad_slot_check #(.SLOT_MAP(vrad_pkg::PBUS_SLOT_MAP)) uPbus (
		.addr(reqAddr),
		.present(pbusPresent)
	);
	vrad_slot_check #(.SLOT_MAP(vrad_pkg::AHB_SLOT_MAP)) uAhb (
		.addr(reqAddr),
		.present(ahbPresent)
	);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	logic inOverlay;
	logic inFlashHole;
	logic inSramHole;
	logic inReserved;
	logic inPbus;
	logic inAhb;
	logic inGap;
	logic emptySlot;
	logic isAbort;

	// Region classification of the incoming address
	always_comb begin
		inOverlay = (reqAddr <= vrad_pkg::OVL_LAST);
		inFlashHole = (reqAddr >= FLASH_END) && (reqAddr <= vrad_pkg::FLASH_LIMIT);
		inSramHole = (reqAddr >= SRAM_END) && (reqAddr <= vrad_pkg::SRAM_LIMIT);
		inReserved = (reqAddr >= vrad_pkg::RSV_BASE) && (reqAddr <= vrad_pkg::RSV_LAST);
		inPbus = (reqAddr >= vrad_pkg::PBUS_BASE) && (reqAddr <= vrad_pkg::PBUS_LAST);
		inAhb = (reqAddr >= vrad_pkg::AHB_BASE);
		inGap = (reqAddr > vrad_pkg::PBUS_LAST) && (reqAddr < vrad_pkg::AHB_BASE);
		// Present slots never abort data, whatever offset is used
		emptySlot = (inPbus && !pbusPresent) || (inAhb && !ahbPresent);
		isAbort = inFlashHole || inSramHole || inReserved || inGap || emptySlot;
	end

	// Next-state: mode register and one registered access stage
	always_comb begin
		st_nxt = st_r;
		if (modeWrite) begin
			case (modeData)
				2'h1: st_nxt.mode = vrad_pkg::MODE_USER_FLASH;
				2'h2: st_nxt.mode = vrad_pkg::MODE_USER_RAM;
				default: st_nxt.mode = vrad_pkg::MODE_BOOT;
			endcase
		end
		st_nxt.valid = reqValid;
		st_nxt.addr = reqAddr;
		st_nxt.write = 1'b0;
		st_nxt.dAbort = 1'b0;
		st_nxt.pAbort = 1'b0;
		if (reqValid) begin
			// Alias only; the home address is left untouched so both stay reachable
			if (inOverlay) begin
				case (st_r.mode)
					vrad_pkg::MODE_BOOT: st_nxt.addr = {vrad_pkg::BOOT_BASE[31:6], reqAddr[5:0]};
					vrad_pkg::MODE_USER_RAM: st_nxt.addr = {vrad_pkg::SRAM_BASE[31:6], reqAddr[5:0]};
					vrad_pkg::MODE_USER_FLASH: st_nxt.addr = reqAddr;
					default: st_nxt.addr = reqAddr;
				endcase
			end
			if (reqFetch) begin
				// Tag only; the core acts on it when the instruction executes
				st_nxt.pAbort = isAbort || inPbus || inAhb;
			end else begin
				st_nxt.dAbort = isAbort;
				st_nxt.write = reqWrite && !isAbort;
			end
		end
	end

	// Register the whole state; reset picks boot loader mapping
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '{mode: vrad_pkg::MODE_BOOT, valid: 1'b0, addr: 32'h0000_0000,
				write: 1'b0, dAbort: 1'b0, pAbort: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rspValid = st_r.valid;
	assign rspAddr = st_r.addr;
	assign rspWrite = st_r.write;
	assign rspDataAbort = st_r.dAbort;
	assign rspPrefetchAbort = st_r.pAbort;
	assign mapMode = st_r.mode;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_BOOT_OVERLAY: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid && reqAddr <= 32'h0000_003F && st_r.mode == vrad_pkg::MODE_BOOT && !modeWrite
		|=> rspAddr[31:6] == 26'h1FFFF40 && rspAddr[5:0] == $past(reqAddr[5:0]))
		else $error("boot overlay address wrong");
	AST_FLASH_NO_OVL: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid && st_r.mode == vrad_pkg::MODE_USER_FLASH |=> rspAddr == $past(reqAddr))
		else $error("user flash mode changed address");
	AST_RAM_OVERLAY: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid && reqAddr <= 32'h0000_003F && st_r.mode == vrad_pkg::MODE_USER_RAM
		|=> rspAddr == {26'h1000000, $past(reqAddr[5:0])})
		else $error("RAM overlay address wrong");
	AST_OVL_EDGE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid && reqAddr == 32'h0000_0040 |=> rspAddr == 32'h0000_0040)
		else $error("address past window remapped");
	AST_RESERVED: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid && reqAddr[31:28] >= 4'h8 && reqAddr[31:28] <= 4'hD
		|=> (rspDataAbort || rspPrefetchAbort) && !rspWrite)
		else $error("reserved region did not abort");
	AST_FETCH_PERIPH: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid && reqFetch && reqAddr[31:21] == 11'h700 |=> rspPrefetchAbort && !rspDataAbort)
		else $error("fetch from peripheral not aborted");
	AST_SLOT_OK: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid && !reqFetch && reqAddr[31:14] == 18'h38003 |=> !rspDataAbort)
		else $error("data abort in present slot");
	AST_FLASH_HOLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid && !reqFetch && reqAddr >= FLASH_END && reqAddr[31:30] == 2'h0
		|=> rspDataAbort ##1 !rspDataAbort || $past(reqValid))
		else $error("flash hole not aborted");
	AST_MODE_LOAD: assert property (@(posedge sys_clk) disable iff (!rst_n)
		modeWrite && modeData == 2'h2 |=> mapMode == 2'(vrad_pkg::MODE_USER_RAM))
		else $error("mode write not taken");

	// ----------------------------------------
	// Vector slots, home mappings and abort classes
	// ----------------------------------------
	// Reset vector fetch lands in the boot block, never aborted
	AST_VEC_RESET: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid && reqFetch && reqAddr == vrad_pkg::VEC_RESET && st_r.mode == vrad_pkg::MODE_BOOT
		|=> rspAddr == (vrad_pkg::BOOT_BASE | vrad_pkg::VEC_RESET) && !rspPrefetchAbort)
		else $error("reset vector not in boot block");
	// Interrupt slot keeps its word offset inside the boot overlay
	AST_VEC_IRQ: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid && reqAddr == vrad_pkg::VEC_IRQ && st_r.mode == vrad_pkg::MODE_BOOT
		|=> rspAddr == (vrad_pkg::BOOT_BASE | vrad_pkg::VEC_IRQ))
		else $error("interrupt vector slot misplaced");
	// Last vector slot keeps its offset inside the RAM overlay
	AST_VEC_FIQ: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid && reqAddr == vrad_pkg::VEC_FIQ && st_r.mode == vrad_pkg::MODE_USER_RAM
		|=> rspAddr == (vrad_pkg::SRAM_BASE | vrad_pkg::VEC_FIQ))
		else $error("fast interrupt vector slot misplaced");
	// Key word reads the bottom of flash once user flash is mapped
	AST_VEC_KEY_FLASH: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid && reqAddr == vrad_pkg::VEC_KEY && st_r.mode == vrad_pkg::MODE_USER_FLASH
		|=> rspAddr == vrad_pkg::VEC_KEY)
		else $error("key word redirected in user flash mode");
	// Flash above the window is never redirected, in any mode
	AST_NO_OVL_ABOVE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid && reqAddr > vrad_pkg::OVL_LAST && reqAddr < FLASH_END
		|=> rspAddr == $past(reqAddr) && !rspDataAbort && !rspPrefetchAbort)
		else $error("flash above window disturbed");
	// Boot block stays reachable at its own fixed address
	AST_BOOT_HOME: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid && reqAddr[31:12] == vrad_pkg::BOOT_BASE[31:12]
		|=> rspAddr == $past(reqAddr) && !rspDataAbort && !rspPrefetchAbort)
		else $error("boot block not at home address");
	// SRAM stays reachable at its own address while overlaid
	AST_SRAM_HOME: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid && reqAddr >= vrad_pkg::SRAM_BASE && reqAddr < SRAM_END
		|=> rspAddr == $past(reqAddr) && !rspDataAbort && !rspPrefetchAbort)
		else $error("SRAM not at home address");
	// Space above the fitted SRAM aborts and never writes
	AST_SRAM_HOLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid && reqAddr >= SRAM_END && reqAddr <= vrad_pkg::SRAM_LIMIT
		|=> (rspDataAbort || rspPrefetchAbort) && !rspWrite)
		else $error("SRAM hole not aborted");
	// Fetch beyond the fitted flash is tagged, not data aborted
	AST_FLASH_HOLE_F: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid && reqFetch && reqAddr >= FLASH_END && reqAddr <= vrad_pkg::FLASH_LIMIT
		|=> rspPrefetchAbort && !rspDataAbort)
		else $error("flash hole fetch not tagged");
	// An aborted access must never reach a memory as a write
	AST_ABORT_NO_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rspDataAbort |-> !rspWrite)
		else $error("write leaked past abort");
	// One access carries at most one kind of abort
	AST_ONE_KIND: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!(rspDataAbort && rspPrefetchAbort))
		else $error("both abort kinds raised");
	// Fetches never write and never raise a data abort
	AST_FETCH_NO_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid && reqFetch
		|=> !rspWrite && !rspDataAbort)
		else $error("fetch wrote or data aborted");
	// No request, no response of any kind
	AST_IDLE_QUIET: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!reqValid
		|=> !rspValid && !rspWrite && !rspDataAbort && !rspPrefetchAbort)
		else $error("response without request");
	// Every request completes in the following cycle
	AST_RSP_VALID: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid
		|=> rspValid)
		else $error("request not completed");
	// A write to fitted flash is passed on
	AST_WRITE_PASS: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid && !reqFetch && reqWrite && reqAddr < FLASH_END
		|=> rspWrite && !rspDataAbort)
		else $error("legal write dropped");
	// Hole between the peripheral bus and the fast bus aborts
	AST_GAP: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid && reqAddr > vrad_pkg::PBUS_LAST && reqAddr < vrad_pkg::AHB_BASE
		|=> (rspDataAbort || rspPrefetchAbort) && !rspWrite)
		else $error("bus gap not aborted");
	// Empty peripheral bus slot aborts a data access
	AST_EMPTY_PBUS: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid && !reqFetch && reqAddr[31:14] == 18'h38006
		|=> rspDataAbort && !rspWrite)
		else $error("empty peripheral slot not aborted");
	// Empty fast bus slot aborts a data access
	AST_EMPTY_AHB: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid && !reqFetch && reqAddr[31:14] == 18'h3FF80
		|=> rspDataAbort && !rspWrite)
		else $error("empty fast bus slot not aborted");
	// Fetch from fast bus space is tagged even in a present slot
	AST_AHB_FETCH: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid && reqFetch && reqAddr >= vrad_pkg::AHB_BASE
		|=> rspPrefetchAbort && !rspDataAbort)
		else $error("fast bus fetch not tagged");
	// Any offset inside a present slot is served, aliasing allowed
	AST_SLOT_ALIAS: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reqValid && !reqFetch && reqAddr[31:14] == 18'h3807F
		|=> !rspDataAbort && rspAddr == $past(reqAddr))
		else $error("present slot offset refused");
	// Mode only moves on a strobe
	AST_MODE_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!modeWrite
		|=> $stable(mapMode))
		else $error("mode changed without strobe");
	// User flash code is taken as written
	AST_MODE_FLASH: assert property (@(posedge sys_clk) disable iff (!rst_n)
		modeWrite && modeData == 2'h1
		|=> mapMode == 2'(vrad_pkg::MODE_USER_FLASH))
		else $error("user flash mode not taken");
	// Spare code falls back to boot mapping, the safe choice
	AST_MODE_THREE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		modeWrite && modeData == 2'h3
		|=> mapMode == 2'(vrad_pkg::MODE_BOOT))
		else $error("spare mode code not boot");
endmodule : vrad_decoder
`default_nettype wire

// >>> hw/vrad_pkg.sv
// Package of constants for the vector remap and abort decoder
package vrad_pkg;
	// ----------------------------------------
	// Mapping modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		MODE_BOOT,
		MODE_USER_FLASH,
		MODE_USER_RAM
	} vrad_mode_e;

	// ----------------------------------------
	// Vector area and overlay window
	// ----------------------------------------
	localparam logic [31:0] VEC_BASE = 32'h0000_0000;
	localparam logic [31:0] VEC_LAST = 32'h0000_001C;
	localparam logic [31:0] VEC_RESET = 32'h0000_0000;
	localparam logic [31:0] VEC_UNDEF = 32'h0000_0004;
	localparam logic [31:0] VEC_SWI = 32'h0000_0008;
	localparam logic [31:0] VEC_PABORT = 32'h0000_000C;
	localparam logic [31:0] VEC_DABORT = 32'h0000_0010;
	localparam logic [31:0] VEC_KEY = 32'h0000_0014;
	localparam logic [31:0] VEC_IRQ = 32'h0000_0018;
	localparam logic [31:0] VEC_FIQ = 32'h0000_001C;
	localparam int OVL_BITS = 6;
	localparam logic [31:0] OVL_LAST = 32'h0000_003F;

	// ----------------------------------------
	// Memory regions
	// ----------------------------------------
	localparam logic [31:0] FLASH_LIMIT = 32'h3FFF_FFFF;
	localparam logic [31:0] SRAM_BASE = 32'h4000_0000;
	localparam logic [31:0] SRAM_LIMIT = 32'h7FFF_CFFF;
	localparam logic [31:0] BOOT_BASE = 32'h7FFF_D000;
	localparam logic [31:0] RSV_BASE = 32'h8000_0000;
	localparam logic [31:0] RSV_LAST = 32'hDFFF_FFFF;
	localparam logic [31:0] PBUS_BASE = 32'hE000_0000;
	localparam logic [31:0] PBUS_LAST = 32'hE01F_FFFF;
	localparam logic [31:0] AHB_BASE = 32'hFFE0_0000;
	localparam int SLOT_BITS = 14;
	localparam int SLOT_IDX_W = 7;
	localparam logic [127:0] PBUS_SLOT_MAP = 128'h8000_0000_0000_0000_0000_0000_0F80_2FBF;
	localparam logic [127:0] AHB_SLOT_MAP = 128'h8000_0000_0000_0000_0000_0000_0000_0000;
endpackage : vrad_pkg

// >>> hw/vrad_slot_check.sv
// Peripheral slot presence lookup
`timescale 1ns/1ps
`default_nettype none
module vrad_slot_check #(
	parameter logic [127:0] SLOT_MAP = 128'h0
) (
	input wire logic [31:0] addr, // Access address
	output logic present // Slot holds a peripheral
);
	// Slot index is address bits 20..14; the rest of the slot is not decoded
	assign present = SLOT_MAP[addr[vrad_pkg::SLOT_BITS +: vrad_pkg::SLOT_IDX_W]];
endmodule : vrad_slot_check
`default_nettype wire

// >>> test/vector_remap_abort_decoder_tb.sv
// Self-checking bench for the vector remap and abort decoder
`timescale 1ns/1ps
`default_nettype none
module vector_remap_abort_decoder_tb;
	localparam int FKB = 32; // Smallest flash, so flash end is easy to reach
	localparam int SKB = 8;
	localparam logic [31:0] FEND = 32'(FKB * 1024);
	localparam logic [31:0] SEND = 32'h4000_0000 + 32'(SKB * 1024);
	logic sys_clk = 1'b0, rst_n = 1'b0, modeWrite = 1'b0;
	logic [1:0] modeData = 2'h0, curMode = 2'h0;
	logic reqValid, reqFetch, reqWrite, rspValid, rspWrite, rspDataAbort, rspPrefetchAbort;
	logic [31:0] reqAddr, rspAddr, seed = 32'h36, pA = 32'h0, r, a;
	logic [1:0] mapMode, pM = 2'h0;
	logic pV = 1'b0, pF = 1'b0, pW = 1'b0;
	logic [3:0] hiTab [8] = '{4'h0, 4'h0, 4'h4, 4'h7, 4'h8, 4'hE, 4'hE, 4'hF};
	logic [31:0] corner [24] = '{32'h0, 32'h14, 32'h1C, 32'h3C, 32'h3F, 32'h40, FEND - 32'h4, FEND,
		32'h3FFF_FFFC, 32'h4000_0000, SEND - 32'h4, SEND, 32'h7FFF_CFFC, 32'h7FFF_D000, 32'h8000_0000,
		32'hDFFF_FFFC, 32'hE000_C000, 32'hE000_D000, 32'hE001_8000, 32'hE01F_C040, 32'hE020_0000,
		32'hFFDF_FFFC, 32'hFFE0_0000, 32'hFFFF_C000};
	int n_errors = 0, num_checks = 0, cycles = 0;

	vrad_core_model core (.reqValid(reqValid), .reqAddr(reqAddr), .reqFetch(reqFetch), .reqWrite(reqWrite));
	vrad_decoder #(.FLASH_KB(FKB), .SRAM_KB(SKB)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .reqValid(reqValid),
		.reqAddr(reqAddr), .reqFetch(reqFetch), .reqWrite(reqWrite), .modeWrite(modeWrite), .modeData(modeData),
		.rspValid(rspValid), .rspAddr(rspAddr), .rspWrite(rspWrite), .rspDataAbort(rspDataAbort),
		.rspPrefetchAbort(rspPrefetchAbort), .mapMode(mapMode));

	// ----------------------------------------
	// Clock, timeout and verdict
	// ----------------------------------------
	always #12.5 sys_clk = ~sys_clk;
	// Ceiling sits far above the roughly 530 cycles the run needs
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			close_out();
		end
	end
	task automatic close_out();
		if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : close_out
	task automatic chk_bit(input logic g, input logic e);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk_bit
	task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk_word

	// ----------------------------------------
	// Expectation functions
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic isAbort(input logic [31:0] x, input logic f);
		if (x >= FEND && x <= 32'h3FFF_FFFF) return 1'b1;
		if (x >= SEND && x <= 32'h7FFF_CFFF) return 1'b1;
		if (x >= 32'h8000_0000 && x <= 32'hDFFF_FFFF) return 1'b1;
		if (x > 32'hE01F_FFFF && x < 32'hFFE0_0000) return 1'b1;
		if (x >= 32'hE000_0000) return f | ~(x[31:21] == 11'h700 ? vrad_pkg::PBUS_SLOT_MAP[x[20:14]]
			: vrad_pkg::AHB_SLOT_MAP[x[20:14]]);
		return 1'b0;
	endfunction : isAbort
	function automatic logic [31:0] expAddr(input logic [31:0] x, input logic [1:0] m);
		if (x > 32'h3F || m == 2'h1) return x;
		return (m == 2'h2 ? 32'h4000_0000 : 32'h7FFF_D000) | {26'h0, x[5:0]};
	endfunction : expAddr

	// ----------------------------------------
	// Drivers: at each falling edge check last answer, then issue
	// ----------------------------------------
	task automatic step(input logic v, input logic [31:0] x, input logic f, input logic w);
		logic ab;
		ab = isAbort(pA, pF);
		chk_bit(rspValid, pV);
		if (pV) begin
			chk_bit(rspDataAbort, ab & ~pF);
			chk_bit(rspPrefetchAbort, ab & pF);
			chk_bit(rspWrite, pW & ~ab);
			chk_word(rspAddr, expAddr(pA, pM));
		end
		core.issue(v, x, f, w);
		{pV, pA, pF, pW, pM} = {v, x, f, w & ~f, curMode};
		@(negedge sys_clk);
	endtask : step
	task automatic setMode(input logic [1:0] m);
		modeWrite = 1'b1;
		modeData = m;
		step(1'b0, 32'h0, 1'b0, 1'b0);
		modeWrite = 1'b0;
		curMode = (m == 2'h3) ? 2'h0 : m;
		chk_word(32'(mapMode), 32'(curMode));
	endtask : setMode

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(negedge sys_clk);
		chk_word({rspValid, rspWrite, rspDataAbort, rspPrefetchAbort, 26'h0, mapMode}, 32'h0);
		rst_n = 1'b1;
		step(1'b1, 32'h0, 1'b1, 1'b0);
		step(1'b1, 32'h14, 1'b0, 1'b0);
		// Every mode code against every boundary, back to back
		for (int m = 0; m < 4; m++) begin
			setMode(2'(m));
			for (int i = 0; i < 24; i++) step(1'b1, corner[i], i % 3 == 0, i % 3 == 1);
		end
		// Random traffic biased toward region edges, with mode changes
		for (int i = 0; i < 400; i++) begin
			r = rnd();
			a = rnd();
			a[31:28] = hiTab[r[2:0]];
			if (r[3]) a[27:21] = (a[31:28] == 4'hF) ? 7'h7F : 7'h00;
			if (r[5:4] == 2'h0) a[31:6] = 26'h0;
			if (i % 50 == 0) setMode(r[7:6]);
			step(r[8] | r[9], a, r[10], r[11]);
		end
		// Reset in mid-run must fall back to boot mapping
		setMode(2'h2);
		step(1'b0, 32'h0, 1'b0, 1'b0);
		rst_n = 1'b0;
		pV = 1'b0;
		repeat (2) @(negedge sys_clk);
		rst_n = 1'b1;
		curMode = 2'h0;
		chk_word(32'(mapMode), 32'h0);
		step(1'b1, 32'h4, 1'b1, 1'b0);
		step(1'b0, 32'h0, 1'b0, 1'b0);
		close_out();
	end
endmodule : vector_remap_abort_decoder_tb
`default_nettype wire

// >>> test/vrad_core_model.sv
// Processor core model issuing fetches and data accesses to the decoder
`timescale 1ns/1ps
`default_nettype none
module vrad_core_model (
	output logic reqValid, // Access request
	output logic [31:0] reqAddr, // Byte address
	output logic reqFetch, // Instruction fetch
	output logic reqWrite // Data write
);
	// ----------------------------------------
	// Request driver
	// ----------------------------------------
	// Idle cycles invert the lines so the decoder cannot lean on stale values
	task automatic issue(input logic v, input logic [31:0] a, input logic f, input logic w);
		reqValid = v;
		reqAddr = v ? a : ~reqAddr;
		reqFetch = v ? f : ~reqFetch;
		reqWrite = v ? w : ~reqWrite; // Write may ride on a fetch; decoder must drop it
	endtask : issue

	// Start idle; the address lines rest on the key word, but no read is requested
	initial begin
		reqValid = 1'b0;
		reqAddr = 32'h0000_0014;
		reqFetch = 1'b0;
		reqWrite = 1'b0;
	end
endmodule : vrad_core_model
`default_nettype wire
